// ### src/tft_host_port_timing_regs.sv
// host parallel port, register bank, pixel packer and line timing
`timescale 1ns/1ps
module tft_host_port_timing_regs (
    input  wire logic        clk_in,             // dot clock, 25 MHz
    input  wire logic        rstn_in,            // async reset, low
    input  wire logic        cs_n_in,            // chip select, low
    input  wire logic        wr_pin_in,          // write strobe / read-not-write
    input  wire logic        rd_pin_in,          // read strobe / enable
    input  wire logic        command_data_select_in, // low address, high data
    input  wire logic        color_depth_select_in,  // low 16-bit, high 18-bit
    input  wire logic        bus_68_in,          // high selects 68-style bus
    input  wire logic [1:0]  bus_width_in,       // 0:8 1:18 2:16 3:18 bits
    input  wire logic [17:0] db_in,              // data pins, input side
    output logic      [17:0] db_out,             // data pins, output side
    output logic             db_oe_out,          // data pins driven
    output logic             ram_we_out,         // display RAM write
    output logic [18:0]      ram_addr_out,       // display RAM address
    output logic [17:0]      ram_data_out,       // display RAM pixel
    input  wire logic        ram_ready_in,       // display RAM accepts
    input  wire logic [17:0] ram_pixel_in,       // pixel read for the panel
    output logic             line_sync_out,      // line sync, high active
    output logic             h_enable_out,       // data enable
    output logic [17:0]      panel_rgb_out,      // panel colour
    output logic [11:0]      dot_count_out,      // dot position in line
    output logic [5:0]       color_order_out     // current serial order code
);
    logic [7:0]  regs_reg [tft_port_pkg::num_regs];
    logic [5:0]  index_reg;
    logic [2:0]  cs_s_reg, wr_s_reg, rd_s_reg, rs_s_reg, cd_s_reg;
    logic [17:0] db_s1_reg, db_s2_reg;
    logic        cs_q, wr_q, rd_q, rs_q, cd_q;
    logic        wr_strobe, rd_strobe;
    tft_port_pkg::pack_state_type pack_state_reg;
    logic [7:0]  byte0_reg, byte1_reg;
    logic [18:0] addr_reg;
    logic [15:0] cur_x_reg, cur_y_reg;
    logic        pix_valid;
    logic [17:0] pix_data;
    logic [15:0] x_begin, x_finish, y_begin, y_finish, stride;
    logic [11:0] sync_begin, sync_width, de_begin, de_width, line_len;
    logic [11:0] dot_reg;
    logic        odd_line_reg;
    logic        ram_write_sel;
    pixel_link_if link_in ();
    pixel_link_if link_out ();

    // two-flop synchronisers for the host select, strobe, depth and data pins
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cs_s_reg  <= 3'h7;
            wr_s_reg  <= 3'h7;
            rd_s_reg  <= 3'h7;
            rs_s_reg  <= 3'h0;
            cd_s_reg  <= 3'h0;
            db_s1_reg <= 18'h00000;
            db_s2_reg <= 18'h00000;
        end else begin
            cs_s_reg  <= {cs_s_reg[1:0], cs_n_in};
            wr_s_reg  <= {wr_s_reg[1:0], wr_pin_in};
            rd_s_reg  <= {rd_s_reg[1:0], rd_pin_in};
            rs_s_reg  <= {rs_s_reg[1:0], command_data_select_in};
            cd_s_reg  <= {cd_s_reg[1:0], color_depth_select_in};
            db_s1_reg <= db_in;
            db_s2_reg <= db_s1_reg;
        end
    end
    assign cs_q = ~cs_s_reg[1];
    assign rs_q = rs_s_reg[1];
    assign cd_q = cd_s_reg[1];
    assign wr_q = wr_s_reg[1];
    assign rd_q = rd_s_reg[1];

    // strobe decode: data taken on the trailing edge
    always_comb begin
        if (bus_68_in) begin
            // write when enable falls with direction write, read when enable rises with direction read
            wr_strobe = rd_s_reg[2] && !rd_q && !wr_q && cs_q;
            rd_strobe = !rd_s_reg[2] && rd_q && wr_q && cs_q;
        end else begin
            wr_strobe = !wr_s_reg[2] && wr_q && cs_q;
            rd_strobe = !rd_q && cs_q;
        end
    end
    assign ram_write_sel = (index_reg == tft_port_pkg::pixel_port);

    // readback drive of the data pins
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            db_out    <= 18'h00000;
            db_oe_out <= 1'b0;
        end else begin
            db_oe_out <= rd_strobe;
            db_out    <= {10'h000, regs_reg[index_reg]};
        end
    end

    // window and timing fields
    assign x_begin    = {regs_reg[tft_port_pkg::win_x_begin_hi],
                         regs_reg[tft_port_pkg::win_x_begin_lo]};
    assign x_finish   = {regs_reg[tft_port_pkg::win_x_finish_hi],
                         regs_reg[tft_port_pkg::win_x_finish_lo]};
    assign y_begin    = {regs_reg[tft_port_pkg::win_y_begin_hi],
                         regs_reg[tft_port_pkg::win_y_begin_lo]};
    assign y_finish   = {regs_reg[tft_port_pkg::win_y_finish_hi],
                         regs_reg[tft_port_pkg::win_y_finish_lo]};
    assign stride     = {regs_reg[tft_port_pkg::row_stride_hi],
                         regs_reg[tft_port_pkg::row_stride_lo]};
    assign sync_begin = {regs_reg[tft_port_pkg::line_sync_begin_hi][3:0],
                         regs_reg[tft_port_pkg::line_sync_begin_lo]};
    assign sync_width = {regs_reg[tft_port_pkg::line_sync_width_hi][3:0],
                         regs_reg[tft_port_pkg::line_sync_width_lo]};
    assign de_begin   = {regs_reg[tft_port_pkg::h_enable_begin_hi][3:0],
                         regs_reg[tft_port_pkg::h_enable_begin_lo]};
    assign de_width   = {regs_reg[tft_port_pkg::h_enable_width_hi][3:0],
                         regs_reg[tft_port_pkg::h_enable_width_lo]};
    assign line_len   = {regs_reg[tft_port_pkg::line_length_hi][3:0],
                         regs_reg[tft_port_pkg::line_length_lo]};

    // register file with reset defaults
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            index_reg <= 6'h00;
            for (int i = 0; i < tft_port_pkg::num_regs; i++) begin
                regs_reg[i] <= 8'h00;
            end
            regs_reg[tft_port_pkg::win_x_finish_hi] <= tft_port_pkg::x_finish_rst[15:8];
            regs_reg[tft_port_pkg::win_x_finish_lo] <= tft_port_pkg::x_finish_rst[7:0];
            regs_reg[tft_port_pkg::win_y_finish_lo] <= tft_port_pkg::y_finish_rst[7:0];
            regs_reg[tft_port_pkg::row_stride_hi]   <= tft_port_pkg::stride_rst[15:8];
            regs_reg[tft_port_pkg::row_stride_lo]   <= tft_port_pkg::stride_rst[7:0];
            regs_reg[tft_port_pkg::panel_output_control] <= tft_port_pkg::out_ctrl_rst;
            regs_reg[tft_port_pkg::line_sync_width_lo] <= tft_port_pkg::sync_width_rst[7:0];
            regs_reg[tft_port_pkg::h_enable_begin_lo] <= tft_port_pkg::de_begin_rst[7:0];
            regs_reg[tft_port_pkg::h_enable_width_hi] <= {4'h0, tft_port_pkg::de_width_rst[11:8]};
            regs_reg[tft_port_pkg::h_enable_width_lo] <= tft_port_pkg::de_width_rst[7:0];
            regs_reg[tft_port_pkg::line_length_hi]  <= {4'h0, tft_port_pkg::line_len_rst[11:8]};
            regs_reg[tft_port_pkg::line_length_lo]  <= tft_port_pkg::line_len_rst[7:0];
        end else if (wr_strobe) begin
            if (!rs_q) begin
                index_reg <= db_s2_reg[5:0];
            end else if (!ram_write_sel) begin
                regs_reg[index_reg] <= db_s2_reg[7:0];
            end
        end
    end

    // pixel assembly from bus transfers
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pack_state_reg <= tft_port_pkg::st_byte0;
            byte0_reg      <= 8'h00;
            byte1_reg      <= 8'h00;
        end else if (wr_strobe && rs_q && ram_write_sel && bus_width_in == 2'h0) begin
            case (pack_state_reg)
                tft_port_pkg::st_byte0: begin
                    byte0_reg      <= db_s2_reg[7:0];
                    pack_state_reg <= tft_port_pkg::st_byte1;
                end
                tft_port_pkg::st_byte1: begin
                    byte1_reg      <= db_s2_reg[7:0];
                    pack_state_reg <= cd_q ? tft_port_pkg::st_byte2 : tft_port_pkg::st_byte0;
                end
                tft_port_pkg::st_byte2: begin
                    pack_state_reg <= tft_port_pkg::st_byte0;
                end
                default: begin
                    pack_state_reg <= tft_port_pkg::st_byte0;
                end
            endcase
        end else if (wr_strobe && !rs_q) begin
            pack_state_reg <= tft_port_pkg::st_byte0;
        end
    end

    // finished pixel, widened to six bits per colour
    always_comb begin
        pix_valid = 1'b0;
        pix_data  = 18'h00000;
        if (wr_strobe && rs_q && ram_write_sel) begin
            case (bus_width_in)
                2'h0: begin
                    if (!cd_q && pack_state_reg == tft_port_pkg::st_byte1) begin
                        pix_valid = 1'b1;
                        pix_data  = {byte0_reg[7:3], 1'b0, byte0_reg[2:0],
                                     db_s2_reg[7:5], db_s2_reg[4:0], 1'b0};
                    end else if (cd_q && pack_state_reg == tft_port_pkg::st_byte2) begin
                        pix_valid = 1'b1;
                        pix_data  = {byte0_reg[1:0], byte1_reg[7:4], byte1_reg[3:0],
                                     db_s2_reg[7:6], db_s2_reg[5:0]};
                    end
                end
                2'h2: begin
                    pix_valid = 1'b1;
                    pix_data  = {db_s2_reg[15:11], 1'b0, db_s2_reg[10:5],
                                 db_s2_reg[4:0], 1'b0};
                end
                default: begin
                    pix_valid = 1'b1;
                    pix_data  = db_s2_reg;
                end
            endcase
        end
    end

    // window address counter
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cur_x_reg <= 16'h0000;
            cur_y_reg <= 16'h0000;
            addr_reg  <= 19'h00000;
        end else if (wr_strobe && rs_q && !ram_write_sel) begin
            // any register write reloads the window origin
            cur_x_reg <= x_begin;
            cur_y_reg <= y_begin;
            addr_reg  <= {regs_reg[tft_port_pkg::ram_wr_origin_top][2:0],
                          regs_reg[tft_port_pkg::ram_wr_origin_mid],
                          regs_reg[tft_port_pkg::ram_wr_origin_low]};
        end else if (pix_valid && link_in.ready) begin
            if (cur_x_reg >= x_finish) begin
                cur_x_reg <= x_begin;
                cur_y_reg <= (cur_y_reg >= y_finish) ? y_begin : cur_y_reg + 16'h0001;
            end else begin
                cur_x_reg <= cur_x_reg + 16'h0001;
            end
        end
    end

    // pixel into the buffer only inside the window
    assign link_in.valid = pix_valid && cur_x_reg >= x_begin && cur_x_reg <= x_finish
                           && cur_y_reg >= y_begin && cur_y_reg <= y_finish;
    // product kept at 19 bits so rows past 65535 dots are not lost
    assign link_in.data  = {addr_reg + 19'(cur_y_reg) * 19'(stride) + 19'(cur_x_reg), pix_data};

    pixel_skid_buffer u_buffer (
        .clk_in  (clk_in),
        .rstn_in (rstn_in),
        .up      (link_in),
        .down    (link_out)
    );

    assign ram_we_out     = link_out.valid;
    assign ram_addr_out   = link_out.data[36:18];
    assign ram_data_out   = link_out.data[17:0];
    assign link_out.ready = ram_ready_in;

    // dot counter and line outputs
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            dot_reg       <= 12'h000;
            odd_line_reg  <= 1'b0;
            line_sync_out <= 1'b0;
            h_enable_out  <= 1'b0;
            panel_rgb_out <= 18'h00000;
        end else begin
            if (dot_reg + 12'h001 >= line_len) begin
                dot_reg      <= 12'h000;
                odd_line_reg <= ~odd_line_reg;
            end else begin
                dot_reg <= dot_reg + 12'h001;
            end
            line_sync_out <= dot_reg >= sync_begin && dot_reg < sync_begin + sync_width;
            h_enable_out  <= dot_reg >= de_begin && dot_reg < de_begin + de_width;
            if (regs_reg[tft_port_pkg::panel_output_control][tft_port_pkg::out_test_bit]) begin
                panel_rgb_out <= {regs_reg[tft_port_pkg::test_red][5:0],
                                  regs_reg[tft_port_pkg::test_green][5:0],
                                  regs_reg[tft_port_pkg::test_blue][5:0]};
            end else begin
                panel_rgb_out <= ram_pixel_in;
            end
        end
    end
    assign dot_count_out   = dot_reg;
    assign color_order_out = odd_line_reg ? {3'h0, regs_reg[tft_port_pkg::serial_color_order][2:0]}
                                          : {3'h0, regs_reg[tft_port_pkg::serial_color_order][5:3]};

    // checks
    property p_line_wrap;
        @(posedge clk_in) disable iff (!rstn_in)
        (dot_reg + 12'h001 >= line_len) |=> dot_reg == 12'h000;
    endproperty
    a_line_wrap: assert property (p_line_wrap) else $error("line did not wrap");
    property p_test_out;
        @(posedge clk_in) disable iff (!rstn_in)
        regs_reg[tft_port_pkg::panel_output_control][tft_port_pkg::out_test_bit]
        && $stable(regs_reg[tft_port_pkg::test_red]) |=>
        panel_rgb_out[17:12] == $past(regs_reg[tft_port_pkg::test_red][5:0]);
    endproperty
    a_test_out: assert property (p_test_out) else $error("test colour wrong");
    property p_in_window;
        @(posedge clk_in) disable iff (!rstn_in)
        link_in.valid |-> cur_x_reg <= x_finish && cur_y_reg <= y_finish;
    endproperty
    a_in_window: assert property (p_in_window) else $error("pixel outside window");
    property p_x_wrap;
        @(posedge clk_in) disable iff (!rstn_in)
        pix_valid && link_in.ready && !(wr_strobe && rs_q && !ram_write_sel)
        && cur_x_reg >= x_finish |=> cur_x_reg == $past(x_begin);
    endproperty
    a_x_wrap: assert property (p_x_wrap) else $error("x did not wrap");
    property p_no_strobe;
        @(posedge clk_in) disable iff (!rstn_in)
        !cs_q |-> !wr_strobe && !rd_strobe;
    endproperty
    a_no_strobe: assert property (p_no_strobe) else $error("strobe without select");
    property p_sync_width;
        @(posedge clk_in) disable iff (!rstn_in)
        dot_reg == sync_begin && sync_width != 12'h000 && $stable(sync_begin) |=> line_sync_out;
    endproperty
    a_sync_width: assert property (p_sync_width) else $error("sync missing");
    property p_de;
        @(posedge clk_in) disable iff (!rstn_in)
        dot_reg == de_begin && de_width != 12'h000 |=> h_enable_out;
    endproperty
    a_de: assert property (p_de) else $error("enable missing");
    property p_rs_index;
        @(posedge clk_in) disable iff (!rstn_in)
        wr_strobe && !rs_q |=> index_reg == $past(db_s2_reg[5:0]);
    endproperty
    a_rs_index: assert property (p_rs_index) else $error("index not taken");
    c_pixel: cover property (@(posedge clk_in) disable iff (!rstn_in) ram_we_out);
    c_stall: cover property (@(posedge clk_in) disable iff (!rstn_in)
        link_in.valid && !link_in.ready);
    c_test: cover property (@(posedge clk_in) disable iff (!rstn_in)
        regs_reg[tft_port_pkg::panel_output_control][tft_port_pkg::out_test_bit]);
endmodule

// ### inc/tft_port_pkg.sv
// constants and types shared by the tft host port design
package tft_port_pkg;
    localparam logic [5:0] win_x_begin_hi     = 6'h00;
    localparam logic [5:0] win_x_begin_lo     = 6'h01;
    localparam logic [5:0] win_x_finish_hi    = 6'h02;
    localparam logic [5:0] win_x_finish_lo    = 6'h03;
    localparam logic [5:0] win_y_begin_hi     = 6'h04;
    localparam logic [5:0] win_y_begin_lo     = 6'h05;
    localparam logic [5:0] win_y_finish_hi    = 6'h06;
    localparam logic [5:0] win_y_finish_lo    = 6'h07;
    localparam logic [5:0] row_stride_hi      = 6'h08;
    localparam logic [5:0] row_stride_lo      = 6'h09;
    localparam logic [5:0] ram_wr_origin_top  = 6'h0a;
    localparam logic [5:0] ram_wr_origin_mid  = 6'h0b;
    localparam logic [5:0] ram_wr_origin_low  = 6'h0c;
    localparam logic [5:0] pixel_port         = 6'h0e;
    localparam logic [5:0] panel_output_control = 6'h10;
    localparam logic [5:0] serial_color_order = 6'h11;
    localparam logic [5:0] line_sync_begin_hi = 6'h12;
    localparam logic [5:0] line_sync_begin_lo = 6'h13;
    localparam logic [5:0] line_sync_width_hi = 6'h14;
    localparam logic [5:0] line_sync_width_lo = 6'h15;
    localparam logic [5:0] h_enable_begin_hi  = 6'h16;
    localparam logic [5:0] h_enable_begin_lo  = 6'h17;
    localparam logic [5:0] h_enable_width_hi  = 6'h18;
    localparam logic [5:0] h_enable_width_lo  = 6'h19;
    localparam logic [5:0] line_length_hi     = 6'h1a;
    localparam logic [5:0] line_length_lo     = 6'h1b;
    localparam logic [5:0] test_red           = 6'h2a;
    localparam logic [5:0] test_green         = 6'h2b;
    localparam logic [5:0] test_blue          = 6'h2c;
    localparam int         num_regs           = 64;
    localparam logic [15:0] x_finish_rst      = 16'h013f;
    localparam logic [15:0] y_finish_rst      = 16'h00ef;
    localparam logic [15:0] stride_rst        = 16'h0140;
    localparam logic [7:0]  out_ctrl_rst      = 8'h0d;
    localparam logic [11:0] sync_width_rst    = 12'h010;
    localparam logic [11:0] de_begin_rst      = 12'h038;
    localparam logic [11:0] de_width_rst      = 12'h140;
    localparam logic [11:0] line_len_rst      = 12'h1b8;
    localparam int          out_test_bit      = 6;
    localparam int          addr_width        = 19;
    localparam int          pixel_width       = 18;
    typedef enum logic [2:0] {
        st_byte0 = 3'b001,
        st_byte1 = 3'b010,
        st_byte2 = 3'b100
    } pack_state_type;
endpackage

// ### inc/pixel_link_if.sv
// valid/ready pixel carrier between the packer and the buffer
`timescale 1ns/1ps
interface pixel_link_if;
    logic        valid;
    logic        ready;
    logic [36:0] data;  // address 19 bits, pixel 18 bits
    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface

// ### src/pixel_skid_buffer.sv
// two-entry pixel buffer with valid and ready on both sides
`timescale 1ns/1ps
module pixel_skid_buffer (
    input  wire logic clk_in,       // dot clock
    input  wire logic rstn_in,      // async reset, low
    pixel_link_if.sink   up,        // from packer
    pixel_link_if.source down       // to display RAM
);
    logic [36:0] mem_reg [2];
    logic [1:0]  count_reg;
    logic        wr_ptr_reg;
    logic        rd_ptr_reg;
    logic        push;
    logic        pop;

    // handshakes
    assign up.ready   = (count_reg != 2'h2);
    assign down.valid = (count_reg != 2'h0);
    assign down.data  = mem_reg[rd_ptr_reg];
    assign push       = up.valid && up.ready;
    assign pop        = down.valid && down.ready;

    // storage
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= up.data;
        end
    end

    // pointers and fill
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            count_reg  <= 2'h0;
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end

    // fill never passes the two entries
    property p_no_overfill;
        @(posedge clk_in) disable iff (!rstn_in)
        count_reg <= 2'h2;
    endproperty
    a_no_overfill: assert property (p_no_overfill) else $error("buffer overfilled");
    c_full: cover property (@(posedge clk_in) disable iff (!rstn_in)
        count_reg == 2'h2);
endmodule

// ### test/host_model.sv
// host microcontroller model driving 80-style register and pixel cycles
`timescale 1ns/1ps
module host_model (
    input  wire logic        clk_in,                  // dot clock
    input  wire logic [17:0] rdata_in,                // device data pins
    output logic             cs_n_out = 1'b1,         // chip select, low
    output logic             wr_n_out = 1'b1,         // write strobe, low
    output logic             rd_n_out = 1'b1,         // read strobe, low
    output logic             command_data_select_out = 1'b0, // low index, high data
    output logic      [17:0] db_out = 18'h00000       // data pins, host side
);
    // one strobe cycle, spaced well past the synchroniser delay
    task automatic bus_cycle(input logic sel, input logic rs, input logic rd,
                             input logic [7:0] v, output logic [7:0] q);
        repeat (2) @(posedge clk_in);
        cs_n_out <= ~sel;
        command_data_select_out <= rs;
        db_out <= {10'h000, v};
        @(posedge clk_in);
        if (rd) rd_n_out <= 1'b0;
        else wr_n_out <= 1'b0;
        repeat (6) @(posedge clk_in);
        q = rdata_in[7:0];
        wr_n_out <= 1'b1;  // rising edge latches the data
        rd_n_out <= 1'b1;
        // hold select and data until the synced rising edge is taken
        repeat (4) @(posedge clk_in);
        cs_n_out <= 1'b1;
        db_out <= ~db_out;  // released lines stop showing the old value
    endtask
endmodule

// ### test/testbench.sv
// self-checking bench for the tft host port and register bank
`timescale 1ns/1ps
module testbench;
    logic        clk_in = 1'b0;
    logic        rstn_in = 1'b0;
    logic        cs_n, wr_n, rd_n, cds, oe, we;
    logic        depth = 1'b0;
    logic        ready = 1'b0;
    logic [17:0] db_host, db_dev, wdata;
    logic [18:0] waddr;
    logic [7:0]  q;
    int          fails = 0;
    int          total_checks = 0;
    int          cycles = 0;
    logic [15:0] rows [12] = '{16'h0201, 16'h033f, 16'h07ef, 16'h0801, 16'h0940,
        16'h100d, 16'h1510, 16'h1738, 16'h1801, 16'h1940, 16'h1a01, 16'h1bb8};
    always #20 clk_in = ~clk_in;
    host_model u_host_model (.clk_in(clk_in), .rdata_in(db_dev), .cs_n_out(cs_n),
        .wr_n_out(wr_n), .rd_n_out(rd_n), .command_data_select_out(cds), .db_out(db_host));
    tft_host_port_timing_regs u_tft_host_port_timing_regs (.clk_in(clk_in),
        .rstn_in(rstn_in), .cs_n_in(cs_n), .wr_pin_in(wr_n), .rd_pin_in(rd_n),
        .command_data_select_in(cds), .color_depth_select_in(depth), .bus_68_in(1'b0),
        .bus_width_in(2'h0), .db_in(db_host), .db_out(db_dev), .db_oe_out(oe),
        .ram_we_out(we), .ram_addr_out(waddr), .ram_data_out(wdata),
        .ram_ready_in(ready), .ram_pixel_in(18'h00000), .line_sync_out(),
        .h_enable_out(), .panel_rgb_out(), .dot_count_out(), .color_order_out());
    task automatic chk(input string what, input logic [18:0] exp, input logic [18:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        u_host_model.bus_cycle(1'b1, 1'b0, 1'b0, a, q);
        u_host_model.bus_cycle(1'b1, 1'b1, 1'b1, 8'h00, q);
    endtask
    task automatic wr_reg(input logic s, input logic [7:0] a, input logic [7:0] v);
        u_host_model.bus_cycle(s, 1'b0, 1'b0, a, q);
        u_host_model.bus_cycle(s, 1'b1, 1'b0, v, q);
    endtask
    // hang guard
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (10) @(posedge clk_in);
        rstn_in <= 1'b1;
        // reset values read back through the bus
        foreach (rows[i]) begin
            rd_reg(rows[i][15:8]);
            chk("reset value", {11'h000, rows[i][7:0]}, {11'h000, q});
        end
        chk("readback released", 19'h00000, {18'h00000, oe});
        wr_reg(1'b1, 8'h13, 8'h5a);
        rd_reg(8'h13);
        chk("sync begin", 19'h0005a, {11'h000, q});
        wr_reg(1'b0, 8'h13, 8'h00);
        rd_reg(8'h13);
        chk("deselected write", 19'h0005a, {11'h000, q});
        // two 16-bit pixels over the byte bus, receiver stalled
        wr_reg(1'b1, 8'h0e, 8'hf8);
        u_host_model.bus_cycle(1'b1, 1'b1, 1'b0, 8'h1f, q);
        repeat (4) @(posedge clk_in);
        chk("pixel valid", 19'h00001, {18'h00000, we});
        chk("pixel addr", 19'h00000, waddr);
        chk("pixel data", 19'h3e03e, {1'b0, wdata});
        ready <= 1'b1;
        @(posedge clk_in);
        ready <= 1'b0;
        u_host_model.bus_cycle(1'b1, 1'b1, 1'b0, 8'h07, q);
        u_host_model.bus_cycle(1'b1, 1'b1, 1'b0, 8'he0, q);
        repeat (4) @(posedge clk_in);
        chk("next addr", 19'h00001, waddr);
        chk("next data", 19'h00fc0, {1'b0, wdata});
        ready <= 1'b1;
        @(posedge clk_in);
        ready <= 1'b0;
        depth <= 1'b1;  // host holds depth high for 18-bit colour
        repeat (4) @(posedge clk_in);
        u_host_model.bus_cycle(1'b1, 1'b1, 1'b0, 8'h03, q);
        u_host_model.bus_cycle(1'b1, 1'b1, 1'b0, 8'hff, q);
        u_host_model.bus_cycle(1'b1, 1'b1, 1'b0, 8'hc0, q);
        repeat (4) @(posedge clk_in);
        chk("third addr", 19'h00002, waddr);
        chk("third data", 19'h3ffc0, {1'b0, wdata});
        tally_and_finish();
    end
endmodule
